// >>> hdl/dmd_decode.sv
// fetch-word decoder, two-word assembly, extra-cycle sequencing and status flags
`timescale 1ns/1ps
`default_nettype none
// How it works
// - each single word is 24 bits; the top 8 bits pick the instruction.
// - a few instructions span two words; both are gathered before issue.
// - a second word has a zero top byte and alone executes as no-op.
// - every two-word instruction issues as taking two cycles.
// - single words take one cycle; extra no-ops follow condition, jump or table read.
// - a taken skip costs two cycles over one word, three over two words.
// - file operand addresses 0 to 0x1FFF; result to that register or W0.
// - bit operations pick bit 0..15 by literal or by a working register.
// - ten-bit literal limited to 255 in byte mode, 1023 in word mode.
// - the 23-bit program address literal must have bit zero clear.
// - ten-bit signed literal is two's complement, -512 to 511.
// - word size by default; suffixes pick byte, double word or shadow set.
// - accumulator write-back goes to W13 or to [W13] with W13 plus 2.
// - X prefetch uses W8 or W9, plain, stepped by 2/4/6, W9+W12, or none.
// - Y prefetch uses W10 or W11, plain, stepped by 2/4/6, W11+W12, or none.
// - X and Y prefetch destinations are W4 through W7.
// - multiply pairs are 4*5,4*6,4*7,5*6,5*7,6*7; squares W4..W7 with itself.
// - five integer flags kept; integer add forms update all five.
// - four accumulator flags kept; accumulator adds touch only those, one cycle.
// - signed accumulator add takes a 16-bit source shifted by a signed literal.
// - add-with-carry forms add carry in and update the five integer flags.
module dmd_decode #(
   parameter int NOP_CYCLES = 1
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               fetch_valid,
   input  wire logic [23:0]        fetch_word,
   output logic                    fetch_ready,
   input  wire logic               exec_stall,
   input  wire logic               cond_true,
   input  wire logic               pc_changed,
   input  wire logic               psv_table_read,
   input  wire logic               skip_taken,
   input  wire dmd_pkg::dmd_fl_t   alu_flags,
   input  wire logic               alu_flags_valid,
   output logic                    dec_valid,
   output dmd_pkg::dmd_dec_t       dec,
   output dmd_pkg::dmd_fl_t        status,
   output logic                    carry_in
);
   if (NOP_CYCLES < 1 || NOP_CYCLES > 3) begin : g_bad_nops
      $error("NOP_CYCLES must lie in 1..3");
   end

   dmd_pkg::dmd_st_t s_r;
   dmd_pkg::dmd_st_t s_nxt;

   function automatic logic is_two(input logic [7:0] op);
      return op == dmd_pkg::OP_CALL2 || op == dmd_pkg::OP_GOTO2 || op == dmd_pkg::OP_MOVD2;
   endfunction

   function automatic dmd_pkg::dmd_pf_t pf_decode(input logic [3:0] code,
                                                 input logic [3:0] base);
      dmd_pkg::dmd_pf_t p;
      logic [2:0]       k;
      p = '0;
      k = 3'(code - ((code >= dmd_pkg::PF_SECOND) ? 4'h7 : 4'h0));
      p.en = code != dmd_pkg::PF_NONE;
      p.areg = base + ((code >= dmd_pkg::PF_SECOND) ? 4'h1 : 4'h0);
      p.indexed = code == dmd_pkg::PF_INDEXED;
      p.step = p.indexed ? 4'sh0 : dmd_pkg::PF_STEP[k];
      return p;
   endfunction

   function automatic dmd_pkg::dmd_dec_t nop_dec(input logic [7:0] op);
      dmd_pkg::dmd_dec_t d;
      d = '0;
      d.cls = dmd_pkg::CL_NOP;
      d.opcode = op;
      d.words = dmd_pkg::WORDS_ONE;
      return d;
   endfunction

   // opcode table values are stand-ins; replace with the core's real encodings
   function automatic dmd_pkg::dmd_dec_t decode_one(input logic [23:0] w);
      dmd_pkg::dmd_dec_t  d;
      dmd_pkg::dmd_ffrm_t ff;
      dmd_pkg::dmd_lfrm_t lf;
      dmd_pkg::dmd_wfrm_t wf;
      dmd_pkg::dmd_5frm_t f5;
      dmd_pkg::dmd_bfrm_t bf;
      dmd_pkg::dmd_afrm_t af;
      dmd_pkg::dmd_mfrm_t mf;
      logic [7:0]         pr;
      d = nop_dec(w[23:16]);
      ff = w;
      lf = w;
      wf = w;
      f5 = w;
      bf = w;
      af = w;
      mf = w;
      pr = '0;
      d.slit = {{6{lf.unsigned_literal_ten[9]}}, lf.unsigned_literal_ten};
      d.use_carry = w[23:16] == dmd_pkg::OP_ADD_WITH_CARRY_OP_F || w[23:16] == dmd_pkg::OP_ADD_WITH_CARRY_OP_L10
                 || w[23:16] == dmd_pkg::OP_ADD_WITH_CARRY_OP_WWW || w[23:16] == dmd_pkg::OP_ADD_WITH_CARRY_OP_LIT5;
      case (w[23:16])
         dmd_pkg::OP_NOP: begin
            d.cls = dmd_pkg::CL_NOP;
         end
         dmd_pkg::OP_ADD_F, dmd_pkg::OP_ADD_WITH_CARRY_OP_F: begin
            d.cls = dmd_pkg::CL_ADD_F;
            d.f_addr = ff.f;
            d.to_file = ff.to_file;
            d.wd = dmd_pkg::REG_FILE_OP_WORKING_REG;
            d.size = ff.size;
            d.illegal = ff.size == dmd_pkg::SZ_RSVD;
            d.flags = dmd_pkg::FL_INT;
         end
         dmd_pkg::OP_ADD_UNSIGNED_LITERAL_TEN, dmd_pkg::OP_ADD_WITH_CARRY_OP_L10: begin
            d.cls = dmd_pkg::CL_ADD_UNSIGNED_LITERAL_TEN;
            d.lit = 23'(lf.unsigned_literal_ten);
            d.wd = lf.wn;
            d.size = lf.size;
            d.illegal = lf.size == dmd_pkg::SZ_RSVD
                     || (lf.size == dmd_pkg::SZ_BYTE && lf.unsigned_literal_ten > dmd_pkg::UNSIGNED_LITERAL_TEN_BYTE_MAX);
            d.flags = dmd_pkg::FL_INT;
         end
         dmd_pkg::OP_ADD_WWW, dmd_pkg::OP_ADD_WITH_CARRY_OP_WWW: begin
            d.cls = dmd_pkg::CL_ADD_WWW;
            d.wb = wf.wb;
            d.ws = wf.ws;
            d.ws_mode = wf.ws_mode;
            d.wd = wf.wd;
            d.size = wf.byte_m ? dmd_pkg::SZ_BYTE : dmd_pkg::SZ_WORD;
            d.flags = dmd_pkg::FL_INT;
         end
         dmd_pkg::OP_ADD_LIT5, dmd_pkg::OP_ADD_WITH_CARRY_OP_LIT5: begin
            d.cls = dmd_pkg::CL_ADD_LIT5;
            d.wb = f5.wb;
            d.wd = f5.wd;
            d.lit = 23'(f5.lit5);
            d.size = f5.size;
            d.shadow = f5.shadow;
            d.illegal = f5.size == dmd_pkg::SZ_RSVD;
            d.flags = dmd_pkg::FL_INT;
         end
         dmd_pkg::OP_ADD_ACC: begin
            d.cls = dmd_pkg::CL_ADD_ACC;
            d.acc_b = af.acc_b;
            d.flags = dmd_pkg::FL_DSP;
         end
         dmd_pkg::OP_ADD_SACC: begin
            d.cls = dmd_pkg::CL_ADD_SACC;
            d.acc_b = af.acc_b;
            d.shift = af.signed_shift_literal;
            d.ws = af.ws;
            d.ws_mode = af.ws_mode;
            d.flags = dmd_pkg::FL_DSP;
         end
         dmd_pkg::OP_BTSC, dmd_pkg::OP_BTSS: begin
            d.cls = dmd_pkg::CL_SKIP;
            d.bit_sel = bf.bit_sel;
            d.bit_from_reg = bf.bit_from_reg;
            d.wb = bf.wb;
            d.ws = bf.ws;
            d.ws_mode = bf.ws_mode;
         end
         dmd_pkg::OP_MAC, dmd_pkg::OP_MAC_W13, dmd_pkg::OP_MAC_W13I, dmd_pkg::OP_SQR: begin
            d.cls = dmd_pkg::CL_MAC;
            d.acc_b = mf.acc_b;
            if (w[23:16] == dmd_pkg::OP_SQR) begin
               d.illegal = mf.mul >= dmd_pkg::SQR_REGS;
               d.mul_a = dmd_pkg::REG_MUL_LO + 4'(mf.mul[1:0]);
               d.mul_b = d.mul_a;
            end else begin
               d.illegal = mf.mul >= dmd_pkg::MUL_PAIRS;
               pr = d.illegal ? 8'h00 : dmd_pkg::MUL_PAIR[mf.mul];
               d.mul_a = pr[7:4];
               d.mul_b = pr[3:0];
            end
            d.xpf = pf_decode(mf.xpf, dmd_pkg::REG_X_BASE);
            d.ypf = pf_decode(mf.ypf, dmd_pkg::REG_Y_BASE);
            d.xd = dmd_pkg::REG_MUL_LO + 4'(mf.xd);
            d.yd = dmd_pkg::REG_MUL_LO + 4'(mf.yd);
            d.awb_en = w[23:16] == dmd_pkg::OP_MAC_W13 || w[23:16] == dmd_pkg::OP_MAC_W13I;
            d.awb_ind = w[23:16] == dmd_pkg::OP_MAC_W13I;
            d.awb_step = d.awb_ind ? dmd_pkg::AWB_STEP : 4'h0;
            d.wd = d.awb_en ? dmd_pkg::REG_AWB : 4'h0;
         end
         default: begin
            d.cls = dmd_pkg::CL_OTHER;
         end
      endcase
      return d;
   endfunction

   function automatic dmd_pkg::dmd_dec_t decode_two(input logic [23:0] w1,
                                                   input logic [23:0] w2);
      dmd_pkg::dmd_dec_t d;
      dmd_pkg::dmd_w1_t  a;
      dmd_pkg::dmd_w2_t  b;
      a = w1;
      b = w2;
      d = nop_dec(a.op);
      d.cls = dmd_pkg::CL_TWO_WORD;
      d.words = dmd_pkg::WORDS_TWO;
      d.lit = {b.hi, a.lo};
      d.illegal = b.zero != 8'h00 || d.lit[0];
      return d;
   endfunction

   logic take;
   logic redirect;
   logic skip_go;
   logic [1:0] fcnt;
   logic fchk;

   assign fetch_ready = !exec_stall;
   assign take = fetch_valid && fetch_ready;
   assign dec_valid = s_r.dec_valid;
   assign dec = s_r.dec;
   assign status = s_r.status;
   assign carry_in = s_r.status.c;

   always_comb begin
      s_nxt = s_r;
      s_nxt.dec_valid = 1'b0;
      skip_go = s_r.dec_valid && s_r.dec.cls == dmd_pkg::CL_SKIP && skip_taken;
      // datapath reports the reason for extra cycles while the instruction is issued
      redirect = s_r.state == dmd_pkg::ST_FIRST && s_r.dec_valid
              && (skip_go || cond_true || pc_changed || psv_table_read);
      fcnt = redirect ? (skip_go ? 2'h1 : 2'(NOP_CYCLES)) : s_r.cnt;
      fchk = redirect ? skip_go : s_r.skip_chk;
      if (redirect) begin
         s_nxt.state = dmd_pkg::ST_NOP;
         s_nxt.cnt = fcnt;
         s_nxt.skip_chk = fchk;
      end
      if (redirect || s_r.state == dmd_pkg::ST_NOP) begin
         // flushed words go out as no-ops so each extra cycle is visible downstream
         if (take) begin
            s_nxt.dec = nop_dec(dmd_pkg::OP_NOP);
            s_nxt.dec_valid = 1'b1;
            s_nxt.skip_chk = 1'b0;
            if (fchk && is_two(fetch_word[23:16])) begin
               s_nxt.cnt = fcnt;
            end else begin
               s_nxt.cnt = fcnt - 2'h1;
               if (fcnt == 2'h1) begin
                  s_nxt.state = dmd_pkg::ST_FIRST;
               end
            end
         end
      end else begin
         case (s_r.state)
            dmd_pkg::ST_FIRST: begin
               if (take && is_two(fetch_word[23:16])) begin
                  s_nxt.first = fetch_word;
                  s_nxt.state = dmd_pkg::ST_SECOND;
               end else if (take) begin
                  s_nxt.dec = decode_one(fetch_word);
                  s_nxt.dec_valid = 1'b1;
               end
            end
            dmd_pkg::ST_SECOND: begin
               if (take) begin
                  s_nxt.dec = decode_two(s_r.first, fetch_word);
                  s_nxt.dec_valid = 1'b1;
                  s_nxt.state = dmd_pkg::ST_FIRST;
               end
            end
            default: begin
               s_nxt.state = dmd_pkg::ST_FIRST;
            end
         endcase
      end
      if (s_nxt.dec_valid) begin
         s_nxt.mask = s_nxt.dec.flags;
         s_nxt.sticky = s_nxt.dec.use_carry;
      end
      if (alu_flags_valid) begin
         s_nxt.status = (s_r.status & ~s_r.mask) | (alu_flags & s_r.mask);
         // carry-chained adds may only clear zero, so a multiword result tests as a whole
         if (s_r.mask.z && s_r.sticky) begin
            s_nxt.status.z = s_r.status.z && alu_flags.z;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence two_first_taken;
      s_r.state == dmd_pkg::ST_FIRST && !redirect && take && is_two(fetch_word[23:16]);
   endsequence
   sequence second_taken;
      s_r.state == dmd_pkg::ST_SECOND && take;
   endsequence

   a_two_word_issue: assert property (two_first_taken ##1 second_taken |=>
      dec_valid && dec.words == dmd_pkg::WORDS_TWO) else $error("two-word not issued");
   a_nop_alone: assert property (s_r.state == dmd_pkg::ST_FIRST && !redirect && take
      && fetch_word[23:16] == 8'h00 |=> dec_valid && dec.cls == dmd_pkg::CL_NOP)
      else $error("zero-top word not a no-op");
   a_single_word: assert property (s_r.state == dmd_pkg::ST_FIRST && !redirect && take
      && !is_two(fetch_word[23:16]) |=> dec_valid && dec.words == dmd_pkg::WORDS_ONE)
      else $error("single word not issued next cycle");
   a_skip_flush: assert property (skip_go && take && !is_two(fetch_word[23:16])
      |=> dec_valid && dec.cls == dmd_pkg::CL_NOP && s_r.state == dmd_pkg::ST_FIRST)
      else $error("skip over one word wrong");
   a_skip_two: assert property (skip_go && take && is_two(fetch_word[23:16])
      |=> dec_valid && dec.cls == dmd_pkg::CL_NOP && s_r.state == dmd_pkg::ST_NOP
      && s_r.cnt == 2'h1 && !s_r.skip_chk)
      else $error("skip over two words wrong");
   a_file_dest: assert property (dec_valid && dec.cls == dmd_pkg::CL_ADD_F
      |-> dec.wd == dmd_pkg::REG_FILE_OP_WORKING_REG && dec.flags == dmd_pkg::FL_INT)
      else $error("file form destination wrong");
   a_unsigned_literal_ten_byte: assert property (dec_valid && dec.cls == dmd_pkg::CL_ADD_UNSIGNED_LITERAL_TEN
      && dec.size == dmd_pkg::SZ_BYTE && dec.lit > 23'h0000FF |-> dec.illegal)
      else $error("byte literal over 255 accepted");
   a_unsigned_literal_twentythree_lsb: assert property (dec_valid && dec.words == dmd_pkg::WORDS_TWO
      && dec.lit[0] |-> dec.illegal) else $error("odd program address accepted");
   a_mul_pairs: assert property (dec_valid && dec.cls == dmd_pkg::CL_MAC && !dec.illegal
      |-> dec.mul_a >= 4'h4 && dec.mul_b <= 4'h7 && dec.mul_a <= dec.mul_b)
      else $error("multiply pair outside W4..W7");
   a_prefetch_reg: assert property (dec_valid && dec.xpf.en && dec.ypf.en
      |-> dec.xpf.areg inside {4'h8, 4'h9} && dec.ypf.areg inside {4'hA, 4'hB})
      else $error("prefetch register out of set");
   a_sticky_zero: assert property (alu_flags_valid && s_r.mask.z && s_r.sticky
      && !s_r.status.z |=> !status.z) else $error("sticky zero was set");
endmodule
`default_nettype wire

// >>> hdl/dmd_pkg.sv
// constants, field layouts and carrier types of the instruction decoder
package dmd_pkg;
   localparam int WORD_W = 24;
   localparam int OP_W   = 8;

   // opcode values for the forms this decoder recognises
   localparam logic [7:0] OP_NOP       = 8'h00;
   localparam logic [7:0] OP_CALL2     = 8'h02;
   localparam logic [7:0] OP_GOTO2     = 8'h04;
   localparam logic [7:0] OP_MOVD2     = 8'hBE;
   localparam logic [7:0] OP_ADD_WWW   = 8'h40;
   localparam logic [7:0] OP_ADD_LIT5  = 8'h41;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_WWW  = 8'h48;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_LIT5 = 8'h49;
   localparam logic [7:0] OP_ADD_UNSIGNED_LITERAL_TEN = 8'hB0;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_L10  = 8'hB1;
   localparam logic [7:0] OP_ADD_F     = 8'hB4;
   localparam logic [7:0] OP_ADD_WITH_CARRY_OP_F    = 8'hB5;
   localparam logic [7:0] OP_BTSS      = 8'hA6;
   localparam logic [7:0] OP_BTSC      = 8'hA7;
   localparam logic [7:0] OP_MAC       = 8'hC0;
   localparam logic [7:0] OP_MAC_W13   = 8'hC1;
   localparam logic [7:0] OP_MAC_W13I  = 8'hC2;
   localparam logic [7:0] OP_SQR       = 8'hC3;
   localparam logic [7:0] OP_ADD_SACC  = 8'hC9;
   localparam logic [7:0] OP_ADD_ACC   = 8'hCB;

   localparam logic [1:0] SZ_WORD  = 2'h0;
   localparam logic [1:0] SZ_BYTE  = 2'h1;
   localparam logic [1:0] SZ_DWORD = 2'h2;
   localparam logic [1:0] SZ_RSVD  = 2'h3;

   localparam logic [9:0] UNSIGNED_LITERAL_TEN_BYTE_MAX = 10'h0FF;
   localparam logic [1:0] WORDS_ONE      = 2'h1;
   localparam logic [1:0] WORDS_TWO      = 2'h2;

   localparam logic [3:0] REG_FILE_OP_WORKING_REG   = 4'h0;
   localparam logic [3:0] REG_MUL_LO = 4'h4;
   localparam logic [3:0] REG_X_BASE = 4'h8;
   localparam logic [3:0] REG_Y_BASE = 4'hA;
   localparam logic [3:0] REG_INDEX  = 4'hC;
   localparam logic [3:0] REG_AWB    = 4'hD;
   localparam logic [3:0] AWB_STEP   = 4'h2;

   localparam logic [3:0] PF_SECOND  = 4'h7;
   localparam logic [3:0] PF_INDEXED = 4'hE;
   localparam logic [3:0] PF_NONE    = 4'hF;
   localparam logic signed [3:0] PF_STEP [0:7] =
      '{4'sh6, 4'sh4, 4'sh2, 4'sh0, -4'sh6, -4'sh4, -4'sh2, 4'sh0};
   localparam logic [2:0] MUL_PAIRS = 3'h6;
   localparam logic [2:0] SQR_REGS  = 3'h4;
   localparam logic [7:0] MUL_PAIR [0:5] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};

   typedef enum logic [3:0] {CL_NOP, CL_ADD_F, CL_ADD_UNSIGNED_LITERAL_TEN, CL_ADD_WWW, CL_ADD_LIT5,
      CL_ADD_ACC, CL_ADD_SACC, CL_SKIP, CL_MAC, CL_TWO_WORD, CL_OTHER} dmd_class_t;
   typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_NOP} dmd_state_t;

   typedef struct packed {
      logic c; logic dc; logic n; logic ov; logic z;
      logic oa; logic ob; logic sa; logic sb;
   } dmd_fl_t;
   localparam dmd_fl_t FL_INT = 9'h1F0;
   localparam dmd_fl_t FL_DSP = 9'h00F;

   typedef struct packed {
      logic              en;
      logic [3:0]        areg;
      logic signed [3:0] step;
      logic              indexed;
   } dmd_pf_t;

   // operand layouts of the 24-bit word, one per form
   typedef struct packed {logic [7:0] op; logic [1:0] size; logic to_file;
      logic [12:0] f;} dmd_ffrm_t;
   typedef struct packed {logic [7:0] op; logic [1:0] size; logic [9:0] unsigned_literal_ten;
      logic [3:0] wn;} dmd_lfrm_t;
   typedef struct packed {logic [7:0] op; logic [3:0] wb; logic [3:0] wd;
      logic [2:0] ws_mode; logic [3:0] ws; logic byte_m;} dmd_wfrm_t;
   typedef struct packed {logic [7:0] op; logic [3:0] wb; logic [3:0] wd;
      logic [4:0] lit5; logic [1:0] size; logic shadow;} dmd_5frm_t;
   typedef struct packed {logic [7:0] op; logic [3:0] wb; logic bit_from_reg;
      logic [2:0] ws_mode; logic [3:0] bit_sel; logic [3:0] ws;} dmd_bfrm_t;
   typedef struct packed {logic [7:0] op; logic acc_b; logic signed [3:0] signed_shift_literal;
      logic [2:0] ws_mode; logic [3:0] ws; logic [3:0] rsvd;} dmd_afrm_t;
   typedef struct packed {logic [7:0] op; logic acc_b; logic [2:0] mul;
      logic [3:0] xpf; logic [1:0] xd; logic [3:0] ypf; logic [1:0] yd;} dmd_mfrm_t;
   typedef struct packed {logic [7:0] op; logic [15:0] lo;} dmd_w1_t;
   typedef struct packed {logic [7:0] zero; logic [8:0] rsvd; logic [6:0] hi;} dmd_w2_t;

   typedef struct packed {
      dmd_class_t        cls;
      logic [7:0]        opcode;
      logic [1:0]        words;
      logic [1:0]        size;
      logic              shadow;
      logic              illegal;
      logic [12:0]       f_addr;
      logic              to_file;
      logic [3:0]        wb;
      logic [3:0]        ws;
      logic [2:0]        ws_mode;
      logic [3:0]        wd;
      logic [22:0]       lit;
      logic signed [15:0] slit;
      logic [3:0]        bit_sel;
      logic              bit_from_reg;
      logic              acc_b;
      logic signed [3:0] shift;
      logic [3:0]        mul_a;
      logic [3:0]        mul_b;
      dmd_pf_t           xpf;
      dmd_pf_t           ypf;
      logic [3:0]        xd;
      logic [3:0]        yd;
      logic              awb_en;
      logic              awb_ind;
      logic [3:0]        awb_step;
      logic              use_carry;
      dmd_fl_t           flags;
   } dmd_dec_t;

   typedef struct packed {
      dmd_state_t  state;
      logic [1:0]  cnt;
      logic        skip_chk;
      logic [23:0] first;
      logic        dec_valid;
      dmd_dec_t    dec;
      dmd_fl_t     mask;
      logic        sticky;
      dmd_fl_t     status;
   } dmd_st_t;
endpackage

// >>> sim/dmd_pmem.sv
// program memory model offering queued instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module dmd_pmem (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        fetch_ready,
   output logic             fetch_valid,
   output logic [23:0]      fetch_word
);
   logic [23:0] q [$];
   logic        taken = 1'b0;
   initial fetch_valid = 1'b0;
   initial fetch_word = 24'h000000;
   always @(posedge clk) taken <= rst_n && fetch_valid && fetch_ready;
   // whole 24-bit words, pairs kept in program order
   always @(negedge clk) begin
      if (taken && q.size() > 0) void'(q.pop_front());
      fetch_valid <= q.size() > 0;
      // an idle bus inverts every bit of the held word on each falling edge
      fetch_word <= (q.size() > 0) ? q[0] : ~fetch_word;
   end
endmodule
`default_nettype wire

// >>> sim/dsp_mcu_instruction_decode_tb.sv
// self-checking bench for the instruction decoder with a reactive datapath
`timescale 1ns/1ps
`default_nettype none
module dsp_mcu_instruction_decode_tb;
   // two flush words, so a hard-wired single extra cycle shows up
   localparam int NC = 2;
   localparam logic [23:0] W_ADDF = {8'hB4, 2'h0, 1'h0, 13'h1FFF};
   localparam logic [23:0] W_L5   = {8'h41, 4'h1, 4'h2, 5'h1F, 2'h2, 1'h1};
   localparam logic [23:0] W_X    = 24'h400000;
   localparam logic [23:0] W_G1   = 24'h041234;
   localparam logic [23:0] W_G2   = 24'h000005;
   logic              clk = 1'b0, rst_n = 1'b0, exec_stall = 1'b0, skip_on = 1'b0;
   logic              cond_true = 1'b0, pc_changed = 1'b0, psv_table_read = 1'b0;
   logic              skip_taken = 1'b0, alu_flags_valid = 1'b0, flush_on = 1'b0;
   logic              fetch_valid, fetch_ready, dec_valid, carry_in, live;
   logic [23:0]       fetch_word;
   dmd_pkg::dmd_fl_t  alu_flags = 9'h000;
   dmd_pkg::dmd_fl_t  status;
   dmd_pkg::dmd_dec_t dec;
   dmd_pkg::dmd_dec_t got [$];
   int                fail_count = 0, checks = 0;

   always #2.5 clk = ~clk;
   dmd_pmem dmd_pmem_i (.clk(clk), .rst_n(rst_n), .fetch_ready(fetch_ready),
      .fetch_valid(fetch_valid), .fetch_word(fetch_word));
   dmd_decode #(.NOP_CYCLES(NC)) dmd_decode_i (.clk(clk), .rst_n(rst_n),
      .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_ready(fetch_ready),
      .exec_stall(exec_stall), .cond_true(cond_true), .pc_changed(pc_changed),
      .psv_table_read(psv_table_read), .skip_taken(skip_taken), .alu_flags(alu_flags),
      .alu_flags_valid(alu_flags_valid), .dec_valid(dec_valid), .dec(dec),
      .status(status), .carry_in(carry_in));
   assign live = dec_valid && dec.cls != dmd_pkg::CL_NOP;
   // the datapath answers within the issue cycle, where the decoder samples it
   always @(negedge clk) begin
      cond_true <= live && flush_on && dec.opcode == 8'hB0;
      pc_changed <= live && flush_on && dec.opcode == 8'h04;
      psv_table_read <= live && flush_on && dec.opcode == 8'hB4;
      skip_taken <= live && skip_on && dec.cls == dmd_pkg::CL_SKIP;
      if (dec_valid === 1'b1) got.push_back(dec);
   end

   task end_sim;
      if (fail_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         fail_count++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task run(input logic [23:0] w [$]);
      int n;
      n = 0;
      got.delete();
      foreach (w[i]) dmd_pmem_i.q.push_back(w[i]);
      while (dmd_pmem_i.q.size() > 0 && n < 500) begin
         @(negedge clk);
         n++;
      end
      repeat (6) @(negedge clk);
      if (n >= 500) begin
         chk(1'b0, "fetch hang");
         end_sim();
      end
   endtask
   task pulse(input dmd_pkg::dmd_fl_t f);
      alu_flags <= f;
      alu_flags_valid <= 1'b1;
      @(negedge clk);
      alu_flags_valid <= 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task s_fields;
      run('{W_ADDF, 24'hA6B8F2, {8'hB0, 2'h1, 10'h100, 4'h1}, 24'hB02001, W_L5});
      chk(got.size() == 5 && got[0].cls === dmd_pkg::CL_ADD_F, "file form");
      chk(got[0].f_addr === 13'h1FFF && got[0].to_file === 1'b0, "file operand");
      chk(got[1].bit_sel === 4'hF && got[1].bit_from_reg === 1'b1, "bit select");
      chk(got[2].illegal === 1'b1 && got[3].illegal === 1'b0, "unsigned_literal_ten range");
      chk(got[3].slit === 16'hFE00, "signed unsigned_literal_ten");
      chk(got[0].size === 2'h0 && got[4].size === 2'h2 && got[4].shadow, "size");
   endtask
   task s_pair;
      fork
         run('{W_G1, W_G2, W_G2, 24'h020001, W_G2});
         begin
            exec_stall <= 1'b1;
            repeat (3) @(negedge clk);
            chk(!fetch_ready && dmd_pmem_i.q.size() == 5, "stall took a word");
            exec_stall <= 1'b0;
         end
      join
      chk(got.size() == 3 && got[0].words === 2'h2, "pair words");
      chk(got[0].lit === 23'h051234 && got[0].illegal === 1'b0, "pair literal");
      chk(got[1].cls === dmd_pkg::CL_NOP, "lone second word");
      chk(got[2].illegal === 1'b1, "odd program address");
   endtask
   task s_skip;
      skip_on <= 1'b1;
      run('{24'hA70000, W_G1, W_G2, 24'hA60000, W_ADDF, W_L5});
      skip_on <= 1'b0;
      chk(got.size() == 6 && got[2].cls === dmd_pkg::CL_NOP, "skip over pair");
      chk(got[4].cls === dmd_pkg::CL_NOP && got[5].cls === dmd_pkg::CL_ADD_LIT5, "skip");
   endtask
   task s_flush;
      flush_on <= 1'b1;
      run('{24'hB00001, W_X, W_X, W_L5, W_G1, W_G2, W_X, W_X, W_L5, W_ADDF, W_X, W_X, W_L5});
      flush_on <= 1'b0;
      chk(got.size() == 12, "flush count");
      for (int i = 1; i < 12; i += 4) begin
         chk(got[i].cls === dmd_pkg::CL_NOP && got[i+1].cls === dmd_pkg::CL_NOP, "nops");
         chk(got[i+2].cls === dmd_pkg::CL_ADD_LIT5, "after flush");
      end
   endtask
   task s_mac;
      run('{24'hC0BE89, 24'hC203FC, 24'hC33CC3, 24'hC0673C, 24'hC103CC});
      chk(got[0].mul_a === 4'h5 && got[0].mul_b === 4'h6 && got[0].acc_b, "pair");
      chk(got[0].xpf.areg === 4'h9 && got[0].xpf.indexed && got[3].xpf.step === 4'sh6
         && got[3].xpf.areg === 4'h9, "x prefetch");
      chk(got[0].ypf.areg === 4'hA && got[0].ypf.step === 4'sh2 && !got[1].ypf.en, "y");
      chk(got[0].xd === 4'h6 && got[0].yd === 4'h5, "prefetch dest");
      chk(got[1].awb_ind && got[1].awb_step === 4'h2 && got[4].awb_ind === 1'b0, "awb");
      chk(got[2].mul_a === 4'h7 && got[2].mul_b === 4'h7 && got[3].illegal, "square");
   endtask
   task s_flags;
      run('{W_ADDF});
      pulse(9'h1FF);
      chk(status === dmd_pkg::FL_INT && carry_in === 1'b1, "int add flags");
      run('{24'hCB0000});
      pulse(9'h00F);
      chk(status === 9'h1FF && got[0].words === 2'h1, "acc add flags");
      run('{24'hB50000});
      pulse(9'h010);
      chk(status === 9'h01F && got[0].use_carry === 1'b1, "carry add");
      pulse(9'h000);
      pulse(9'h010);
      chk(status === 9'h00F && carry_in === 1'b0, "sticky zero");
      run('{24'hC9F030});
      pulse(9'h000);
      chk(got[0].shift === -4'sh2 && got[0].ws === 4'h3 && status === 9'h000, "sacc");
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      s_fields();
      s_pair();
      s_skip();
      s_flush();
      s_mac();
      s_flags();
      end_sim();
   end
endmodule
`default_nettype wire
